// ===== core/adcc_pkg.sv
package adcc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_MODE0   = 8'h00;
  localparam logic [7:0] OFS_CHSEL   = 8'h04;
  localparam logic [7:0] OFS_CMPMODE = 8'h08;
  localparam logic [7:0] OFS_THRESH  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_RESULT0 = 8'h20;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODE0_ENABLE = 0;
  localparam int MODE0_HSPEED = 1;
  localparam int MODE0_TRG_LO = 2;
  localparam int MODE0_SCAN   = 4;
  localparam int MODE0_ONESHT = 5;
  localparam int MODE0_START  = 6;
  localparam int CMP_COND     = 6;
  localparam int CMP_ENABLE   = 7;
  localparam int IRQ_CONV_END = 0;
  localparam int IRQ_TRG_ERR  = 1;

  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int NUM_CH  = 8;
  localparam int CH_W    = 3;
  localparam int RES_W   = 10;
  localparam int NUM_IRQ = 2;
  localparam logic [6:0]       MODE0_RST  = 7'h00;
  localparam logic [CH_W-1:0]  CHSEL_RST  = 3'h0;
  localparam logic [7:0]       CMP_RST    = 8'h00;
  localparam logic [7:0]       THRESH_RST = 8'h00;
  localparam logic [RES_W-1:0] RESULT_RST = 10'h000;

  // ****************************************
  // Trigger modes
  // ****************************************
  localparam logic [1:0] TRG_SOFT  = 2'h0;
  localparam logic [1:0] TRG_EXT   = 2'h1;
  localparam logic [1:0] TRG_TIMER = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ      = 20;
  localparam int STAB_TIME_NS = 1000;
  localparam int STAB_CYC     = (STAB_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] STAB_CNT = 8'(STAB_CYC);

  function automatic logic [7:0] upper_byte(input logic [RES_W-1:0] res);
    return res[RES_W-1 -: 8];
  endfunction

endpackage

// ===== core/adcc_cmp.sv
`timescale 1ns/100ps
module adcc_cmp (
  input  wire logic [7:0] upper,
  input  wire logic [7:0] thresh,
  input  wire logic       cond,
  output logic            hit
);
  // One relation for both select and scan
  assign hit = cond ? (upper < thresh) : (upper >= thresh);
endmodule

// ===== core/adcc_ahb_slv.sv
`timescale 1ns/100ps
module adcc_ahb_slv (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [7:0]       reg_addr
);
  logic       wr_q, wr_d;
  logic       rd_q, rd_d;
  logic [7:0] addr_q, addr_d;

  // Zero wait states: data phase always completes in one cycle
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign reg_wr    = wr_q;
  assign reg_rd    = rd_q;
  assign reg_addr  = addr_q;

  always_comb begin
    wr_d   = 1'b0;
    rd_d   = 1'b0;
    addr_d = addr_q;
    if (hsel && hready && htrans[1]) begin
      wr_d   = hwrite;
      rd_d   = !hwrite;
      addr_d = {haddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q   <= wr_d;
      rd_q   <= rd_d;
      addr_q <= addr_d;
    end
  end
endmodule

// ===== core/adcc_top.sv
`timescale 1ns/100ps
module adcc_top (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [7:0]                haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  input  wire logic                      ext_trigger,
  input  wire logic                      timer_trigger,
  output logic                           conv_start,
  output logic [adcc_pkg::CH_W-1:0]      conv_channel,
  input  wire logic                      conv_done,
  input  wire logic [adcc_pkg::RES_W-1:0] conv_data,
  output logic                           analog_power_on,
  output logic                           conversion_end_irq,
  output logic                           irq
);

  // ****************************************
  // Bus slave
  // ****************************************
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;

  adcc_ahb_slv i_adcc_ahb_slv (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_addr  (reg_addr)
  );

  // ****************************************
  // Registers
  // ****************************************
  typedef enum logic [1:0] {ST_OFF, ST_STAB, ST_WAIT, ST_CONV} adcc_state_e;

  adcc_state_e                    st_q, st_d;
  logic [6:0]                     mode_q, mode_d;
  logic [adcc_pkg::CH_W-1:0]      chsel_q, chsel_d;
  logic [7:0]                     cmp_q, cmp_d;
  logic [7:0]                     thr_q, thr_d;
  logic [adcc_pkg::NUM_IRQ-1:0]   ist_q, ist_d;
  logic [adcc_pkg::NUM_IRQ-1:0]   imsk_q, imsk_d;
  logic [7:0]                     stab_q, stab_d;
  logic [adcc_pkg::CH_W-1:0]      ch_q, ch_d;
  logic                           start_q, start_d;
  logic                           sw_go_q, sw_go_d;
  logic                           eoc_q, eoc_d;
  logic [adcc_pkg::RES_W-1:0]     res_q [adcc_pkg::NUM_CH];
  logic [adcc_pkg::RES_W-1:0]     res_d [adcc_pkg::NUM_CH];

  logic       enable;
  logic       scan;
  logic       one_shot;
  logic [1:0] trg_mode;
  logic       trigger;
  logic       cmp_on;
  logic       hit;
  logic       store;
  logic       last_ch;
  logic       ev_conv_end;
  logic       ev_trg_err;
  logic       wr_sel;
  logic       enable_nxt;

  assign enable   = mode_q[adcc_pkg::MODE0_ENABLE];
  assign scan     = mode_q[adcc_pkg::MODE0_SCAN];
  assign one_shot = mode_q[adcc_pkg::MODE0_ONESHT];
  assign trg_mode = mode_q[adcc_pkg::MODE0_TRG_LO +: 2];
  assign cmp_on   = cmp_q[adcc_pkg::CMP_ENABLE];
  assign last_ch  = scan ? (ch_q == chsel_q) : 1'b1;

  // Hardware triggers only count in their own mode
  assign trigger = (trg_mode == adcc_pkg::TRG_EXT   && ext_trigger) ||
                   (trg_mode == adcc_pkg::TRG_TIMER && timer_trigger);

  // ****************************************
  // Compare filter
  // ****************************************
  adcc_cmp i_adcc_cmp (
    .upper  (adcc_pkg::upper_byte(conv_data)),
    .thresh (thr_q),
    .cond   (cmp_q[adcc_pkg::CMP_COND]),
    .hit    (hit)
  );

  always_comb begin
    store       = 1'b0;
    ev_conv_end = 1'b0;
    if (st_q == ST_CONV && conv_done) begin
      if (!cmp_on) begin
        store       = 1'b1;
        ev_conv_end = last_ch;
      end else if (!scan) begin
        store       = hit;
        ev_conv_end = hit;
      end else if (ch_q == '0) begin
        store       = hit;
        ev_conv_end = hit;
      end else begin
        store       = 1'b1;
        ev_conv_end = 1'b0;
      end
    end
  end

  // Trigger inside stabilization is dropped and flagged
  assign ev_trg_err = (st_q == ST_STAB) && trigger;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    st_d       = st_q;
    stab_d     = stab_q;
    ch_d       = ch_q;
    start_d    = 1'b0;
    sw_go_d    = sw_go_q;
    for (int i = 0; i < adcc_pkg::NUM_CH; i++) begin
      res_d[i] = res_q[i];
    end
    if (wr_sel && reg_addr == adcc_pkg::OFS_MODE0 && hwdata[adcc_pkg::MODE0_START]) begin
      sw_go_d = 1'b1;
    end
    unique case (st_q)
      ST_OFF: begin
        if (enable) begin
          st_d   = ST_STAB;
          stab_d = adcc_pkg::STAB_CNT;
        end
      end
      ST_STAB: begin
        // One-time settling after enable; triggers here are dropped but flagged in IRQ_TRG_ERR
        if (stab_q == 8'h01) begin
          st_d = ST_WAIT;
        end
        stab_d = stab_q - 8'h01;
      end
      ST_WAIT: begin
        // Channel set while idle so it is settled when the start pulse leaves
        ch_d = scan ? '0 : chsel_q;
        if ((trg_mode == adcc_pkg::TRG_SOFT) ? (sw_go_q || !one_shot) : trigger) begin
          st_d    = ST_CONV;
          start_d = 1'b1;
          sw_go_d = 1'b0;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          if (store) begin
            res_d[ch_q] = conv_data;
          end
          if (!last_ch) begin
            ch_d    = ch_q + 3'h1;
            start_d = 1'b1;
          end else begin
            st_d = ST_WAIT;
          end
        end
      end
    endcase
    // Clearing enable aborts and powers down; next enable settles again
    if (!enable_nxt) begin
      st_d    = ST_OFF;
      start_d = 1'b0;
      sw_go_d = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q    <= ST_OFF;
      stab_q  <= 8'h00;
      ch_q    <= '0;
      start_q <= 1'b0;
      sw_go_q <= 1'b0;
      for (int i = 0; i < adcc_pkg::NUM_CH; i++) begin
        res_q[i] <= adcc_pkg::RESULT_RST;
      end
    end else begin
      st_q    <= st_d;
      stab_q  <= stab_d;
      ch_q    <= ch_d;
      start_q <= start_d;
      sw_go_q <= sw_go_d;
      for (int i = 0; i < adcc_pkg::NUM_CH; i++) begin
        res_q[i] <= res_d[i];
      end
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  assign wr_sel = reg_wr;
  // Abort on the value being written, so no start pulse outlives power-down
  assign enable_nxt = mode_d[adcc_pkg::MODE0_ENABLE];

  always_comb begin
    mode_d  = mode_q;
    chsel_d = chsel_q;
    cmp_d   = cmp_q;
    thr_d   = thr_q;
    imsk_d  = imsk_q;
    ist_d   = ist_q;
    eoc_d   = ev_conv_end;
    if (wr_sel) begin
      unique case (reg_addr)
        adcc_pkg::OFS_MODE0: begin
          mode_d = {1'b0, hwdata[5:0]};
        end
        adcc_pkg::OFS_CHSEL:   chsel_d = hwdata[adcc_pkg::CH_W-1:0];
        // Taken as written; software is to stop the converter first
        adcc_pkg::OFS_CMPMODE: cmp_d   = {hwdata[7:6], 6'h00};
        adcc_pkg::OFS_THRESH:  thr_d   = hwdata[7:0];
        adcc_pkg::OFS_IRQ_MSK: imsk_d  = hwdata[adcc_pkg::NUM_IRQ-1:0];
        adcc_pkg::OFS_IRQ_ST:  ist_d   = ist_q & ~hwdata[adcc_pkg::NUM_IRQ-1:0];
        default: begin
        end
      endcase
    end
    // Set wins over a same-cycle clear
    if (ev_conv_end) begin
      ist_d[adcc_pkg::IRQ_CONV_END] = 1'b1;
    end
    if (ev_trg_err) begin
      ist_d[adcc_pkg::IRQ_TRG_ERR] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q  <= adcc_pkg::MODE0_RST;
      chsel_q <= adcc_pkg::CHSEL_RST;
      cmp_q   <= adcc_pkg::CMP_RST;
      thr_q   <= adcc_pkg::THRESH_RST;
      imsk_q  <= '0;
      ist_q   <= '0;
      eoc_q   <= 1'b0;
    end else begin
      mode_q  <= mode_d;
      chsel_q <= chsel_d;
      cmp_q   <= cmp_d;
      thr_q   <= thr_d;
      imsk_q  <= imsk_d;
      ist_q   <= ist_d;
      eoc_q   <= eoc_d;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  // Zero outside a read data phase, so idle bus cycles show no register state
  always_comb begin
    hrdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        adcc_pkg::OFS_MODE0:   hrdata = {26'h0, mode_q[5:0]};
        adcc_pkg::OFS_CHSEL:   hrdata = {29'h0, chsel_q};
        adcc_pkg::OFS_CMPMODE: hrdata = {24'h0, cmp_q};
        adcc_pkg::OFS_THRESH:  hrdata = {24'h0, thr_q};
        adcc_pkg::OFS_IRQ_ST:  hrdata = {30'h0, ist_q};
        adcc_pkg::OFS_IRQ_MSK: hrdata = {30'h0, imsk_q};
        adcc_pkg::OFS_STATUS: begin
          hrdata = {26'h0, ch_q, (st_q == ST_CONV), (st_q == ST_STAB), (st_q != ST_OFF)};
        end
        default: begin
          if (reg_addr[7:5] == 3'h1) begin
            hrdata = {22'h0, res_q[reg_addr[4:2]]};
          end
        end
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign conv_start         = start_q;
  assign conv_channel       = ch_q;
  assign analog_power_on    = enable;
  assign conversion_end_irq = eoc_q;
  assign irq                = |(ist_q & imsk_q);

endmodule

// ===== verification/adcc_assertions.sv
`timescale 1ns/100ps
module adcc_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic        analog_power_on,
  input wire logic        conversion_end_irq
);
  localparam int STAB_MIN = adcc_pkg::STAB_CYC - 1;
  // ****
  // Helper state
  // ****
  logic       rdph_q, rdph_d;
  logic [7:0] pwr_cnt_q, pwr_cnt_d;
  always_comb begin
    rdph_d    = hsel & hready & htrans[1] & ~hwrite;
    pwr_cnt_d = pwr_cnt_q;
    if (!analog_power_on) begin
      pwr_cnt_d = 8'h00;
    end else if (pwr_cnt_q != 8'hFF) begin
      pwr_cnt_d = pwr_cnt_q + 8'h01;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdph_q    <= 1'b0;
      pwr_cnt_q <= 8'h00;
    end else begin
      rdph_q    <= rdph_d;
      pwr_cnt_q <= pwr_cnt_d;
    end
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_powerup;
    $rose(analog_power_on);
  endsequence
  sequence s_quiet;
    !conv_start [*8];
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  AST_RD_IDLE: assert property (!rdph_q |-> hrdata == 32'h0) else $error("read data outside data phase");
  AST_RD_UPPER: assert property (rdph_q |-> hrdata[31:10] == 22'h0) else $error("read data upper bits set");
  AST_STAB_QUIET: assert property (s_powerup |-> s_quiet)
    else $error("conversion started right after enable");
  AST_STAB_LEN: assert property (conv_start |-> pwr_cnt_q >= STAB_MIN)
    else $error("conversion started inside stabilization");
  AST_OFF_NO_START: assert property (!analog_power_on |-> !conv_start)
    else $error("conversion started while disabled");
  AST_IRQ_CAUSE: assert property (conversion_end_irq |-> $past(conv_done) && $past(analog_power_on))
    else $error("conversion end irq without finished conversion");
  AST_IRQ_PULSE: assert property (conversion_end_irq |=> !conversion_end_irq)
    else $error("conversion end irq longer than one cycle");
  AST_START_PULSE: assert property (conv_start |=> !conv_start) else $error("start pulse too long");
endmodule
bind adcc_top adcc_checker i_adcc_checker (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .conv_start, .conv_done, .analog_power_on, .conversion_end_irq);

// ===== verification/adcc_top_tb.sv
`timescale 1ns/100ps
module adcc_top_tb;
  // ****
  // Signals
  // ****
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hreadyout, hresp, ext_trigger, timer_trigger;
  logic        conv_start, conv_done, analog_power_on, conversion_end_irq, irq;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata;
  logic [2:0]  conv_channel;
  logic [9:0]  conv_data;
  int          n_errors = 0, cmp_count = 0, n_irq = 0, cyc = 0, n0;
  always #25 hclk = ~hclk;
  adcc_top i_adcc_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_trigger, .timer_trigger, .conv_start,
    .conv_channel, .conv_done, .conv_data, .analog_power_on, .conversion_end_irq, .irq);
  // ****
  // Tasks
  // ****
  task automatic print_verdict;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask
  task automatic lvl(input logic e);
    @(negedge hclk);
    chk(32'(irq), 32'(e));
    @(posedge hclk);
  endtask
  // Enable dropped around every compare write
  task automatic setup(input logic [2:0] ch, input logic [7:0] cmp, input logic [7:0] mode);
    wr(adcc_pkg::OFS_MODE0, 32'h0);
    wr(adcc_pkg::OFS_CHSEL, 32'(ch));
    wr(adcc_pkg::OFS_CMPMODE, 32'(cmp));
    wr(adcc_pkg::OFS_THRESH, 32'h40);
    wr(adcc_pkg::OFS_MODE0, 32'(mode));
  endtask
  task automatic conv(input logic [9:0] d, input logic [2:0] ch);
    int i;
    i = 0;
    #1;
    while (conv_start !== 1'b1 && i < 200) begin
      @(posedge hclk);
      #1;
      i++;
    end
    chk({conv_start, conv_channel}, {1'b1, ch});
    @(posedge hclk);
    conv_data <= d;
    conv_done <= 1'b1;
    @(posedge hclk);
    conv_done <= 1'b0;
  endtask
  task automatic sel(input logic [9:0] d, input int hit);
    n0 = n_irq;
    wr(adcc_pkg::OFS_MODE0, 32'h61);
    conv(d, 3'h2);
    repeat (3) @(posedge hclk);
    chk(n_irq - n0, hit);
  endtask
  task automatic trig(input int m);
    if (m == 1) timer_trigger <= 1'b1;
    else ext_trigger <= 1'b1;
    @(posedge hclk);
    timer_trigger <= 1'b0;
    ext_trigger <= 1'b0;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (conversion_end_irq === 1'b1) n_irq++;
    if (cyc == 8000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    {hresetn, hsel, hwrite, ext_trigger, timer_trigger, conv_done} = 6'h00;
    {haddr, htrans, hwdata, conv_data} = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rc(adcc_pkg::OFS_MODE0, 32'h0);
    rc(adcc_pkg::OFS_CMPMODE, 32'h0);
    rc(adcc_pkg::OFS_RESULT0, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rc(8'h40, 32'h0);
    $display("test reset done");
    for (int c = 0; c < 2; c++) begin
      setup(3'h2, c ? 8'hC0 : 8'h80, 8'h21);
      repeat (25) @(posedge hclk);
      rc(adcc_pkg::OFS_STATUS, 32'h11);
      for (int k = 0; k < 2; k++) sel(k ? 10'h0FC : 10'h100, int'(k == c));
      rc(adcc_pkg::OFS_RESULT0 + 8'h08, c ? 32'h0FC : 32'h100);
    end
    $display("test select done");
    rc(adcc_pkg::OFS_IRQ_ST, 32'h1);
    lvl(1'b0);
    wr(adcc_pkg::OFS_IRQ_MSK, 32'h1);
    lvl(1'b1);
    wr(adcc_pkg::OFS_IRQ_ST, 32'h1);
    lvl(1'b0);
    $display("test interrupt done");
    setup(3'h2, 8'h80, 8'h31);
    repeat (25) @(posedge hclk);
    for (int h = 0; h < 2; h++) begin
      n0 = n_irq;
      wr(adcc_pkg::OFS_MODE0, 32'h71);
      conv(h ? 10'h100 : 10'h0C0, 3'h0);
      conv(10'h155, 3'h1);
      conv(10'h2AA, 3'h2);
      repeat (3) @(posedge hclk);
      chk(n_irq - n0, h);
      rc(adcc_pkg::OFS_RESULT0 + 8'h04, 32'h155);
      rc(adcc_pkg::OFS_RESULT0 + 8'h08, 32'h2AA);
      rc(adcc_pkg::OFS_RESULT0, h ? 32'h100 : 32'h0);
    end
    rc(adcc_pkg::OFS_RESULT0, 32'h100);
    $display("test scan done");
    for (int m = 0; m < 2; m++) begin
      wr(adcc_pkg::OFS_IRQ_ST, 32'h3);
      setup(3'h0, 8'h00, m ? 8'h0B : 8'h07);
      repeat (3) @(posedge hclk);
      trig(m);
      repeat (25) @(posedge hclk);
      rc(adcc_pkg::OFS_IRQ_ST, 32'h2);
      n0 = n_irq;
      trig(m);
      conv(10'h123, 3'h0);
      repeat (3) @(posedge hclk);
      chk(n_irq - n0, 1);
      rc(adcc_pkg::OFS_RESULT0, 32'h123);
    end
    $display("test trigger done");
    @(negedge hclk);
    chk(32'(analog_power_on), 32'h1);
    @(posedge hclk);
    wr(adcc_pkg::OFS_MODE0, 32'h0);
    rc(adcc_pkg::OFS_STATUS, 32'h0);
    @(negedge hclk);
    chk(32'(analog_power_on), 32'h0);
    $display("test power done");
    print_verdict();
  end
endmodule
